// file: logic/pfc_pkg.sv
// Constants, register map and types of the pack protection switch block.
// Operation
// - Low cell or cold pack: precharge on, charge off.
// - All cells above threshold, warm: charge on.
// - Over-voltage, over-temperature, over-current or short turns charge and precharge off.
// - Charging above thresholds keeps discharge switch on.
// - During discharge charge switch needs healthy flow.
// - Discharge drive is high after reset.
// - Under-voltage, over-current or fault turns discharge off.
// - Safety over-voltage fires fuse, which then opens switches.
// - Switches still closed after opening fire fuse.
// - External switch inputs watched, polarity programmable.
// - Every safety condition waits its own delay.
// - Voltage limits except safety over-voltage release only past programmable hysteresis.
// - Temperature and current limits have own timers.
// - Dedicated current trips act without the controller.
// - Button shows charge on three to five lamps.
// - Coulomb counter integrates both ways, 18 bits, deadband.
// - Current sampled together with cell voltages, 14 bits.
// - One trigger starts all four cell conversions.
// - Balancing enabled separately for charge, discharge, rest.
package pfc_pkg;
  localparam int NCOND = 9;
  localparam int C_CELL_OV = 0;
  localparam int C_CELL_UV = 1;
  localparam int C_PACK_OV = 2;
  localparam int C_PACK_UV = 3;
  localparam int C_TEMP_HI = 4;
  localparam int C_TEMP_LO = 5;
  localparam int C_OVER_CUR = 6;
  localparam int C_SHORT = 7;
  localparam int C_SAFE_OV = 8;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_CELL_OV = 6'h08;
  localparam logic [5:0] OFF_CELL_UV = 6'h0c;
  localparam logic [5:0] OFF_PRECHG = 6'h10;
  localparam logic [5:0] OFF_PACK_OV = 6'h14;
  localparam logic [5:0] OFF_PACK_UV = 6'h18;
  localparam logic [5:0] OFF_HYST = 6'h1c;
  localparam logic [5:0] OFF_TEMP = 6'h20;
  localparam logic [5:0] OFF_DELAY0 = 6'h24;
  localparam logic [5:0] OFF_DELAY1 = 6'h28;
  localparam logic [5:0] OFF_FUSE = 6'h2c;
  localparam logic [5:0] OFF_SAFE_OV = 6'h30;
  localparam logic [5:0] OFF_LEVEL = 6'h34;
  localparam logic [5:0] OFF_COULOMB = 6'h38;
  localparam logic [5:0] OFF_BAL_SEL = 6'h3c;
  localparam int CTRL_POL_LSB = 0;
  localparam int CTRL_EXTMODE = 2;
  localparam int CTRL_DOT = 3;
  localparam int CTRL_LAMPS_LSB = 4;
  localparam int CTRL_BAL_CHG = 7;
  localparam int CTRL_BAL_DSG = 8;
  localparam int CTRL_BAL_REST = 9;
  localparam int ST_FUSE = 9;
  localparam int ST_CHG = 10;
  localparam int ST_PRE = 11;
  localparam int ST_DSG = 12;
  localparam logic [9:0] CTRL_RST = 10'h053;
  localparam logic [15:0] CELL_OV_RST = 16'h1068;
  localparam logic [15:0] CELL_UV_RST = 16'h0bb8;
  localparam logic [15:0] PRECHG_RST = 16'h0a8c;
  localparam logic [17:0] PACK_OV_RST = 18'h041a0;
  localparam logic [17:0] PACK_UV_RST = 18'h02ee0;
  localparam logic [31:0] HYST_RST = 32'h0190_0064;
  localparam logic [11:0] TEMP_MAX_RST = 12'hd88;
  localparam logic [11:0] TEMP_MIN_RST = 12'haab;
  localparam logic [31:0] DELAY_RST = 32'h1010_1010;
  localparam logic [15:0] FUSE_RST = 16'h4040;
  localparam logic [15:0] SAFE_OV_RST = 16'h1130;
  localparam logic [6:0] LEVEL_RST = 7'h00;
  localparam logic [3:0] BAL_SEL_RST = 4'h0;
  localparam logic [13:0] CC_DEADBAND = 14'h0004;
  localparam logic [6:0] LEVEL_FULL = 7'h64;
  localparam logic [2:0] LAMP_MIN = 3'h3;
  localparam logic [2:0] LAMP_MAX = 3'h5;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_PERIOD_US = 1000;
  localparam int CONV_CYCLES_DEF = CONV_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam longint LAMP_TIME_MS = 4000;
  localparam longint LAMP_CYCLES_DEF = LAMP_TIME_MS * 1000000000 / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    LAMP_IDLE = 2'b01,
    LAMP_SHOW = 2'b10
  } pfc_lamp_state_t;
endpackage

// file: logic/pfc_top.sv
// Pack protection switch control with Avalon-MM register access.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pfc_top #(
  parameter int unsigned CONV_CYCLES = pfc_pkg::CONV_CYCLES_DEF,
  parameter int unsigned LAMP_CYCLES = 32'(pfc_pkg::LAMP_CYCLES_DEF)
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [pfc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Converters.
  output logic convStart,
  input wire logic convDone,
  input wire logic [15:0] cellVolt0,
  input wire logic [15:0] cellVolt1,
  input wire logic [15:0] cellVolt2,
  input wire logic [15:0] cellVolt3,
  input wire logic signed [13:0] packCurrent,
  input wire logic [11:0] temperature,
  input wire logic ccValid,
  input wire logic signed [13:0] ccSample,
  input wire logic overCurrentTrip,
  input wire logic shortCircuitTrip,
  // Switches and fuse.
  output logic chargeSwitchDrive,
  output logic prechargeSwitchDrive,
  output logic dischargeSwitchDrive,
  output logic fuseDrive,
  input wire logic chargeSwitchClosed,
  input wire logic dischargeSwitchClosed,
  input wire logic [1:0] externalSwitchInputs,
  // Lamps and balancing.
  input wire logic lampEnableButton,
  output logic [4:0] chargeLampSinks,
  output logic [3:0] balanceEnable
);
  import pfc_pkg::*;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [9:0] ctrl_reg;
  logic [15:0] cellOvTh_reg, cellUvTh_reg, prechgTh_reg, safeOvTh_reg;
  logic [17:0] packOvTh_reg, packUvTh_reg;
  logic [31:0] hyst_reg, delay0_reg, delay1_reg;
  logic [11:0] tempMax_reg, tempMin_reg;
  logic [15:0] fuseCfg_reg;
  logic [6:0] level_reg;
  logic [3:0] balSel_reg;
  logic ack_reg;
  logic [31:0] readdata_reg, rdValue, wrMerged;
  logic wrEn, ccClear;
  logic [15:0] cellVolt_reg [4];
  logic signed [13:0] packCurrent_reg;
  logic [31:0] convCnt_reg;
  logic convStart_reg;
  logic [NCOND-1:0] condQual_reg, condRaw, condHold;
  logic [7:0] qualTimer_reg [NCOND];
  logic [7:0] condDelay [NCOND];
  logic [15:0] cellMax, cellMin;
  logic [17:0] packSum;
  logic [1:0] extActive;
  logic extChgOff, extDsgOff, chgBlock, dsgBlock, preMode;
  logic charging, discharging;
  logic chg_reg, pre_reg, dsg_reg, fuse_reg;
  logic switchStuck;
  logic [7:0] stuckTimer_reg;
  logic signed [17:0] ccAcc_reg;
  logic [13:0] ccMag;
  pfc_lamp_state_t lampState_reg;
  logic [31:0] lampTimer_reg;
  logic btnPrev_reg;
  logic [4:0] lamps_reg;
  logic [3:0] bal_reg;

  function automatic logic [31:0] beMerge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b+:8] = wd[8*b+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] lampsUsed(input logic [2:0] n);
    if (n < LAMP_MIN) begin
      return LAMP_MIN;
    end
    if (n > LAMP_MAX) begin
      return LAMP_MAX;
    end
    return n;
  endfunction

  function automatic logic [4:0] lampPattern(input logic [6:0] level,
    input logic [2:0] n, input logic dot);
    logic [6:0] lv;
    logic [9:0] k;
    logic [4:0] p;
    lv = (level > LEVEL_FULL) ? LEVEL_FULL : level;
    k = ({3'h0, lv} * {7'h00, n} + {3'h0, LEVEL_FULL} - 10'h001)
      / {3'h0, LEVEL_FULL};
    p = 5'h00;
    for (int j = 0; j < 5; j++) begin
      if (dot) begin
        p[j] = (k == 10'(j + 1));
      end else begin
        p[j] = (k > 10'(j));
      end
    end
    return p;
  endfunction

  // Register bus: one wait cycle, then the answer stands for one edge.
  assign waitrequest = (read | write) & ~ack_reg;
  assign readdata = readdata_reg;
  assign wrEn = write & ack_reg;
  assign ccClear = wrEn & (address == OFF_COULOMB);
  // Merging into the read view keeps unused bits of narrow registers zero.
  assign wrMerged = beMerge(rdValue, writedata, byteenable);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
      if (read & ~ack_reg) begin
        readdata_reg <= rdValue;
      end
    end
  end

  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (address)
      OFF_CTRL: rdValue = {22'h000000, ctrl_reg};
      OFF_STATUS: rdValue = {19'h00000, dsg_reg, pre_reg, chg_reg,
        fuse_reg, condQual_reg};
      OFF_CELL_OV: rdValue = {16'h0000, cellOvTh_reg};
      OFF_CELL_UV: rdValue = {16'h0000, cellUvTh_reg};
      OFF_PRECHG: rdValue = {16'h0000, prechgTh_reg};
      OFF_PACK_OV: rdValue = {14'h0000, packOvTh_reg};
      OFF_PACK_UV: rdValue = {14'h0000, packUvTh_reg};
      OFF_HYST: rdValue = hyst_reg;
      OFF_TEMP: rdValue = {4'h0, tempMin_reg, 4'h0, tempMax_reg};
      OFF_DELAY0: rdValue = delay0_reg;
      OFF_DELAY1: rdValue = delay1_reg;
      OFF_FUSE: rdValue = {16'h0000, fuseCfg_reg};
      OFF_SAFE_OV: rdValue = {16'h0000, safeOvTh_reg};
      OFF_LEVEL: rdValue = {25'h0000000, level_reg};
      OFF_COULOMB: rdValue = {{14{ccAcc_reg[17]}}, ccAcc_reg};
      OFF_BAL_SEL: rdValue = {28'h0000000, balSel_reg};
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      cellOvTh_reg <= CELL_OV_RST;
      cellUvTh_reg <= CELL_UV_RST;
      prechgTh_reg <= PRECHG_RST;
      packOvTh_reg <= PACK_OV_RST;
      packUvTh_reg <= PACK_UV_RST;
      hyst_reg <= HYST_RST;
      tempMax_reg <= TEMP_MAX_RST;
      tempMin_reg <= TEMP_MIN_RST;
      delay0_reg <= DELAY_RST;
      delay1_reg <= DELAY_RST;
      fuseCfg_reg <= FUSE_RST;
      safeOvTh_reg <= SAFE_OV_RST;
      level_reg <= LEVEL_RST;
      balSel_reg <= BAL_SEL_RST;
    end else if (wrEn) begin
      unique case (address)
        OFF_CTRL: ctrl_reg <= wrMerged[9:0];
        OFF_CELL_OV: cellOvTh_reg <= wrMerged[15:0];
        OFF_CELL_UV: cellUvTh_reg <= wrMerged[15:0];
        OFF_PRECHG: prechgTh_reg <= wrMerged[15:0];
        OFF_PACK_OV: packOvTh_reg <= wrMerged[17:0];
        OFF_PACK_UV: packUvTh_reg <= wrMerged[17:0];
        OFF_HYST: hyst_reg <= wrMerged;
        OFF_TEMP: begin
          tempMax_reg <= wrMerged[11:0];
          tempMin_reg <= wrMerged[27:16];
        end
        OFF_DELAY0: delay0_reg <= wrMerged;
        OFF_DELAY1: delay1_reg <= wrMerged;
        OFF_FUSE: fuseCfg_reg <= wrMerged[15:0];
        OFF_SAFE_OV: safeOvTh_reg <= wrMerged[15:0];
        OFF_LEVEL: level_reg <= wrMerged[6:0];
        OFF_BAL_SEL: balSel_reg <= wrMerged[3:0];
        default: ;
      endcase
    end
  end

  // One trigger starts every cell converter and the current converter.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      convCnt_reg <= 32'h0000_0000;
      convStart_reg <= 1'b0;
    end else begin
      convStart_reg <= (convCnt_reg == CONV_CYCLES - 1);
      convCnt_reg <= (convCnt_reg == CONV_CYCLES - 1) ? 32'h0000_0000
        : convCnt_reg + 32'h0000_0001;
    end
  end
  assign convStart = convStart_reg;

  conv_pulse_a: assert property (convStart |=> !convStart)
    else $error("conversion trigger longer than one cycle");

  // Current is latched on the same strobe as the cells.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int c = 0; c < 4; c++) begin
        cellVolt_reg[c] <= 16'h0000;
      end
      packCurrent_reg <= 14'sh0000;
    end else if (convDone) begin
      cellVolt_reg[0] <= cellVolt0;
      cellVolt_reg[1] <= cellVolt1;
      cellVolt_reg[2] <= cellVolt2;
      cellVolt_reg[3] <= cellVolt3;
      packCurrent_reg <= packCurrent;
    end
  end

  always_comb begin
    cellMax = cellVolt_reg[0];
    cellMin = cellVolt_reg[0];
    packSum = 18'h00000;
    for (int c = 0; c < 4; c++) begin
      if (cellVolt_reg[c] > cellMax) begin
        cellMax = cellVolt_reg[c];
      end
      if (cellVolt_reg[c] < cellMin) begin
        cellMin = cellVolt_reg[c];
      end
      packSum = packSum + {2'h0, cellVolt_reg[c]};
    end
  end

  // A tripped voltage limit other than safety over-voltage holds until it is clear by the hysteresis.
  always_comb begin
    condRaw[C_CELL_OV] = cellMax > cellOvTh_reg;
    condHold[C_CELL_OV] = {1'b0, cellMax} + {1'b0, hyst_reg[15:0]}
      > {1'b0, cellOvTh_reg};
    condRaw[C_CELL_UV] = cellMin < cellUvTh_reg;
    condHold[C_CELL_UV] = {1'b0, cellMin}
      < {1'b0, cellUvTh_reg} + {1'b0, hyst_reg[15:0]};
    condRaw[C_PACK_OV] = packSum > packOvTh_reg;
    condHold[C_PACK_OV] = {1'b0, packSum} + {3'h0, hyst_reg[31:16]}
      > {1'b0, packOvTh_reg};
    condRaw[C_PACK_UV] = packSum < packUvTh_reg;
    condHold[C_PACK_UV] = {1'b0, packSum}
      < {1'b0, packUvTh_reg} + {3'h0, hyst_reg[31:16]};
    condRaw[C_TEMP_HI] = temperature > tempMax_reg;
    condRaw[C_TEMP_LO] = temperature < tempMin_reg;
    condRaw[C_OVER_CUR] = overCurrentTrip;
    condRaw[C_SHORT] = shortCircuitTrip;
    condRaw[C_SAFE_OV] = cellMax > safeOvTh_reg;
    for (int i = C_TEMP_HI; i < NCOND; i++) begin
      condHold[i] = condRaw[i];
    end
    for (int i = 0; i < 4; i++) begin
      condDelay[i] = delay0_reg[8*i+:8];
      condDelay[i+4] = delay1_reg[8*i+:8];
    end
    condDelay[C_SAFE_OV] = fuseCfg_reg[7:0];
  end

  // Each condition qualifies only after its own delay; a short glitch
  // restarts the count, trading response time for noise immunity.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      condQual_reg <= '0;
      for (int i = 0; i < NCOND; i++) begin
        qualTimer_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NCOND; i++) begin
        if (condQual_reg[i]) begin
          qualTimer_reg[i] <= 8'h00;
          if (!condHold[i]) begin
            condQual_reg[i] <= 1'b0;
          end
        end else if (!condRaw[i]) begin
          qualTimer_reg[i] <= 8'h00;
        end else if (qualTimer_reg[i] >= condDelay[i]) begin
          condQual_reg[i] <= 1'b1;
          qualTimer_reg[i] <= 8'h00;
        end else begin
          qualTimer_reg[i] <= qualTimer_reg[i] + 8'h01;
        end
      end
    end
  end

  qual_delay_a: assert property (
    $rose(condQual_reg[C_OVER_CUR]) |->
    $past(qualTimer_reg[C_OVER_CUR]) == $past(condDelay[C_OVER_CUR]))
    else $error("over-current qualified early");
  timer_clear_a: assert property (!condRaw[C_OVER_CUR] &&
    !condQual_reg[C_OVER_CUR] |=> qualTimer_reg[C_OVER_CUR] == 8'h00)
    else $error("qualification timer kept count");

  // Switch decisions.
  always_comb begin
    extActive = ~(externalSwitchInputs ^ ctrl_reg[CTRL_POL_LSB+:2]);
    extChgOff = ctrl_reg[CTRL_EXTMODE] ? extActive[0] : |extActive;
    extDsgOff = ctrl_reg[CTRL_EXTMODE] ? extActive[1] : |extActive;
    charging = packCurrent_reg > 14'sh0000;
    discharging = packCurrent_reg < 14'sh0000;
    chgBlock = condQual_reg[C_CELL_OV] | condQual_reg[C_PACK_OV]
      | condQual_reg[C_TEMP_HI] | condQual_reg[C_OVER_CUR]
      | condQual_reg[C_SHORT] | extChgOff | fuse_reg;
    dsgBlock = condQual_reg[C_CELL_UV] | condQual_reg[C_PACK_UV]
      | condQual_reg[C_TEMP_HI] | condQual_reg[C_OVER_CUR]
      | condQual_reg[C_SHORT] | extDsgOff | fuse_reg;
    preMode = (cellMin < prechgTh_reg) | condQual_reg[C_TEMP_LO];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chg_reg <= 1'b0;
      pre_reg <= 1'b0;
      dsg_reg <= 1'b1;
    end else begin
      pre_reg <= !chgBlock;
      chg_reg <= !chgBlock && !preMode
        && !(discharging && dsgBlock);
      dsg_reg <= !dsgBlock;
    end
  end
  assign chargeSwitchDrive = chg_reg;
  assign prechargeSwitchDrive = pre_reg;
  assign dischargeSwitchDrive = dsg_reg;

  sequence precharge_seq;
    preMode && !chgBlock;
  endsequence
  precharge_mode_a: assert property (precharge_seq |=>
    prechargeSwitchDrive && !chargeSwitchDrive)
    else $error("precharge mode drives charge switch");
  charge_path_a: assert property (
    !preMode && !chgBlock && !discharging
    |=> chargeSwitchDrive && prechargeSwitchDrive)
    else $error("charge path not enabled");
  cutoff_low_a: assert property (chgBlock |=>
    !chargeSwitchDrive && !prechargeSwitchDrive)
    else $error("charge drives on at cutoff");
  dsg_reset_a: assert property ($past(rst) |->
    dischargeSwitchDrive)
    else $error("discharge drive low after reset");
  dsg_off_a: assert property (condQual_reg[C_CELL_UV] |=>
    !dischargeSwitchDrive)
    else $error("discharge on under low cell");
  dsg_charging_a: assert property (charging && !dsgBlock |=>
    dischargeSwitchDrive)
    else $error("discharge off while charging");

  // Fuse: a switch that stays closed after being opened, or a safety
  // over-voltage, blows the pack for good; only reset clears it.
  assign switchStuck = (!chg_reg && chargeSwitchClosed)
    || (!dsg_reg && dischargeSwitchClosed);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stuckTimer_reg <= 8'h00;
      fuse_reg <= 1'b0;
    end else begin
      if (!switchStuck) begin
        stuckTimer_reg <= 8'h00;
      end else if (stuckTimer_reg >= fuseCfg_reg[15:8]) begin
        fuse_reg <= 1'b1;
      end else begin
        stuckTimer_reg <= stuckTimer_reg + 8'h01;
      end
      if (condQual_reg[C_SAFE_OV]) begin
        fuse_reg <= 1'b1;
      end
    end
  end
  assign fuseDrive = fuse_reg;

  sequence stuck_expire_seq;
    switchStuck && stuckTimer_reg >= fuseCfg_reg[15:8];
  endsequence
  fuse_fire_a: assert property (stuck_expire_seq |=> fuseDrive)
    else $error("fuse not fired on stuck switch");
  fuse_hold_a: assert property (fuseDrive |=> fuseDrive[*2])
    else $error("fuse drive released");

  // Coulomb counter runs on its own strobe and never waits on the bus.
  assign ccMag = ccSample[13] ? 14'(-ccSample) : ccSample;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ccAcc_reg <= 18'sh00000;
    end else if (ccValid && ccMag > CC_DEADBAND) begin
      ccAcc_reg <= (ccClear ? 18'sh00000 : ccAcc_reg)
        + {{4{ccSample[13]}}, ccSample};
    end else if (ccClear) begin
      ccAcc_reg <= 18'sh00000;
    end
  end

  cc_deadband_a: assert property (ccValid && ccMag <= CC_DEADBAND
    && !ccClear |=> $stable(ccAcc_reg))
    else $error("deadband sample accumulated");

  // Lamp display.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lampState_reg <= LAMP_IDLE;
      lampTimer_reg <= 32'h0000_0000;
      btnPrev_reg <= 1'b0;
      lamps_reg <= 5'h00;
    end else begin
      btnPrev_reg <= lampEnableButton;
      unique case (lampState_reg)
        LAMP_IDLE: begin
          lamps_reg <= 5'h00;
          lampTimer_reg <= 32'h0000_0000;
          if (lampEnableButton && !btnPrev_reg) begin
            lampState_reg <= LAMP_SHOW;
          end
        end
        LAMP_SHOW: begin
          lamps_reg <= lampPattern(level_reg,
            lampsUsed(ctrl_reg[CTRL_LAMPS_LSB+:3]),
            ctrl_reg[CTRL_DOT]);
          lampTimer_reg <= lampTimer_reg + 32'h0000_0001;
          if (lampTimer_reg == LAMP_CYCLES - 1) begin
            lampState_reg <= LAMP_IDLE;
          end
        end
      endcase
    end
  end
  assign chargeLampSinks = lamps_reg;

  sequence lamp_show_seq;
    lampState_reg == LAMP_SHOW ##1 chargeLampSinks == lampPattern(level_reg,
      lampsUsed(ctrl_reg[CTRL_LAMPS_LSB+:3]), ctrl_reg[CTRL_DOT]);
  endsequence
  lamp_press_a: assert property (lampState_reg == LAMP_IDLE
    && lampEnableButton && !btnPrev_reg |=> lamp_show_seq)
    else $error("button press not shown");

  // Balancing per operating mode.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bal_reg <= 4'h0;
    end else if (charging ? ctrl_reg[CTRL_BAL_CHG]
        : discharging ? ctrl_reg[CTRL_BAL_DSG]
        : ctrl_reg[CTRL_BAL_REST]) begin
      bal_reg <= balSel_reg;
    end else begin
      bal_reg <= 4'h0;
    end
  end
  assign balanceEnable = bal_reg;
endmodule

// file: test/pfc_pack_model.sv
// Behavioural model of the converters and the protection switches.
`timescale 1ns/1ps
module pfc_pack_model (
  // Clock.
  input wire logic ref_clk,
  // Converter handshake.
  input wire logic convStart,
  output logic convDone,
  // Switch gates and sense.
  input wire logic chargeSwitchDrive,
  input wire logic dischargeSwitchDrive,
  input wire logic stuck,
  output logic chargeSwitchClosed,
  output logic dischargeSwitchClosed
);
  logic [2:0] convPipe = 3'h0;
  logic [1:0] chgDly = 2'h0;
  logic [1:0] dsgDly = 2'h0;
  // Switches settle slowly, so the sense lags the gate by two cycles.
  always @(posedge ref_clk) begin
    convPipe <= {convPipe[1:0], convStart};
    chgDly <= {chgDly[0], chargeSwitchDrive};
    dsgDly <= {dsgDly[0], dischargeSwitchDrive};
  end
  assign convDone = convPipe[2];
  // A welded switch stays closed whatever its gate sees.
  assign chargeSwitchClosed = stuck | chgDly[1];
  assign dischargeSwitchClosed = stuck | dsgDly[1];
endmodule

// file: test/tb.sv
// Self-checking bench for the pack protection switch block.
`timescale 1ns/1ps
module tb;
  import pfc_pkg::*;
  logic ref_clk = 0, rst = 1, read = 0, write = 0, convStart, convDone;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0] byteenable = 4'hf;
  logic waitrequest, ccValid = 0, overCurrentTrip = 0, stuck = 0;
  logic [15:0] cellVolt [4];
  logic signed [13:0] packCurrent = 14'sd0, ccSample = 14'sd0;
  logic [11:0] temperature = 12'hc00;
  logic charge_switch_drive, pre, discharge_switch_drive, fuse, chgClosed, dsgClosed, lampBtn = 0;
  logic [1:0] extIn = 2'h0;
  logic [4:0] lamps;
  logic [3:0] bal, bsel;
  logic scTrip = 0;
  int cnt = 0, lvl = 0;
  int errors = 0, tests_run = 0, seed = 32'h71dce928;
  initial forever #2 ref_clk = ~ref_clk;
  initial for (int i = 0; i < 4; i++) cellVolt[i] = 16'h0e00;
  pfc_top #(.CONV_CYCLES(16), .LAMP_CYCLES(20)) dut (.ref_clk(ref_clk),
    .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .convStart(convStart), .convDone(convDone),
    .cellVolt0(cellVolt[0]), .cellVolt1(cellVolt[1]),
    .cellVolt2(cellVolt[2]), .cellVolt3(cellVolt[3]),
    .packCurrent(packCurrent), .temperature(temperature), .ccValid(ccValid),
    .ccSample(ccSample), .overCurrentTrip(overCurrentTrip),
    .shortCircuitTrip(scTrip), .chargeSwitchDrive(charge_switch_drive),
    .prechargeSwitchDrive(pre), .dischargeSwitchDrive(discharge_switch_drive), .fuseDrive(fuse),
    .chargeSwitchClosed(chgClosed), .dischargeSwitchClosed(dsgClosed),
    .externalSwitchInputs(extIn), .lampEnableButton(lampBtn),
    .chargeLampSinks(lamps), .balanceEnable(bal));
  pfc_pack_model partner (.ref_clk(ref_clk), .convStart(convStart),
    .convDone(convDone), .chargeSwitchDrive(charge_switch_drive),
    .dischargeSwitchDrive(discharge_switch_drive), .stuck(stuck),
    .chargeSwitchClosed(chgClosed), .dischargeSwitchClosed(dsgClosed));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until waitrequest is sampled low at an edge.
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    r = readdata;
    read <= 0;
    write <= 0;
    @(posedge ref_clk);
  endtask
  // Lit count is the level share of the lamps, rounded up.
  function automatic logic [4:0] expLamps(input int pct, input int n,
                                          input int dot);
    int k;
    n = (n < 3) ? 3 : (n > 5) ? 5 : n;
    k = ((pct > 100 ? 100 : pct) * n + 99) / 100;
    if (dot) return (k == 0) ? 5'h00 : 5'(1 << (k - 1));
    return 5'((1 << k) - 1);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(20000);
    errors++;
    conclude();
  end
  initial begin
    cyc(3);
    rst <= 0;
    @(negedge ref_clk);
    chk(discharge_switch_drive, 1'b1);
    chk({charge_switch_drive, pre, fuse}, 3'h0);
    @(posedge ref_clk);
    bus(1'b0, OFF_CTRL, 32'h0, q);
    chk(q, 32'(CTRL_RST));
    bus(1'b0, 6'h02, 32'h0, q);
    chk(q, 32'h0);
    repeat (64) begin
      @(posedge ref_clk);
      cnt += convStart;
    end
    chk(cnt, 64 / 16);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++)
        cellVolt[i] <= 16'h0e00 + 16'($random(seed) & 32'h1ff);
      cyc(80);
      chk({charge_switch_drive, discharge_switch_drive}, 2'b11);
    end
    cellVolt[2] <= 16'h0a00;
    cyc(80);
    chk({pre, charge_switch_drive, discharge_switch_drive}, 3'b100);
    cellVolt[2] <= 16'h0e00;
    cyc(80);
    overCurrentTrip <= 1;
    cyc(6);
    overCurrentTrip <= 0;
    cyc(30);
    chk({charge_switch_drive, discharge_switch_drive}, 2'b11);
    overCurrentTrip <= 1;
    cyc(40);
    chk({charge_switch_drive, pre, discharge_switch_drive}, 3'b000);
    overCurrentTrip <= 0;
    cyc(40);
    scTrip <= 1;
    cyc(40);
    chk({charge_switch_drive, pre, discharge_switch_drive}, 3'b000);
    scTrip <= 0;
    cyc(40);
    temperature <= 12'h900;
    cyc(40);
    chk({pre, charge_switch_drive, discharge_switch_drive}, 3'b101);
    temperature <= 12'he00;
    cyc(40);
    chk({pre, charge_switch_drive, discharge_switch_drive}, 3'b000);
    temperature <= 12'hc00;
    cyc(40);
    extIn <= 2'b01;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive}, 2'b00);
    bus(1'b1, OFF_CTRL, 32'h050, q);
    extIn <= 2'b11;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive}, 2'b11);
    bus(1'b1, OFF_CTRL, 32'h053, q);
    extIn <= 2'b00;
    for (int m = 0; m < 4; m++) begin
      lvl = $random(seed) & 32'h7f;
      bus(1'b1, OFF_LEVEL, 32'(lvl), q);
      bus(1'b1, OFF_CTRL, 32'(3 + (m % 2) * 8 + (3 + m) * 16), q);
      lampBtn <= 1;
      cyc(4);
      chk(lamps, expLamps(lvl, 3 + m, m % 2));
      lampBtn <= 0;
      cyc(30);
      chk(lamps, 5'h00);
    end
    bsel = 4'($random(seed)) | 4'h1;
    bus(1'b1, OFF_BAL_SEL, {28'h0, bsel}, q);
    bus(1'b1, OFF_CTRL, 32'h287, q);
    extIn <= 2'b10;
    packCurrent <= -14'sd100;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive, bal}, {2'b00, 4'h0});
    packCurrent <= 14'sd100;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive, bal}, {2'b10, bsel});
    extIn <= 2'b00;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive, bal}, {2'b11, bsel});
    packCurrent <= 14'sd0;
    cyc(40);
    chk({charge_switch_drive, discharge_switch_drive, bal}, {2'b11, bsel});
    bus(1'b1, OFF_COULOMB, 32'h0, q);
    ccValid <= 1;
    ccSample <= 14'sd10;
    cyc(1);
    ccSample <= -14'sd3;
    cyc(1);
    ccSample <= -14'sd20;
    cyc(1);
    ccValid <= 0;
    cyc(2);
    bus(1'b0, OFF_COULOMB, 32'h0, q);
    chk(q, 32'hfffffff6);
    stuck <= 1;
    overCurrentTrip <= 1;
    cyc(160);
    chk({fuse, charge_switch_drive, discharge_switch_drive}, 3'b100);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk(q[ST_FUSE], 1'b1);
    conclude();
  end
endmodule
